// file: spi_fram_cfg.svh
`ifndef SPI_FRAM_CFG_SVH
`define SPI_FRAM_CFG_SVH

// opcodes
`define OP_LATCH_SET        8'h06
`define OP_LATCH_CLEAR      8'h04
`define OP_STATUS_READ      8'h05
`define OP_STATUS_WRITE     8'h01
`define OP_ARRAY_WRITE      8'h02
`define OP_ARRAY_READ       8'h03
`define OP_FAST_ARRAY_READ  8'h0B
`define OP_SS_WRITE         8'h42
`define OP_SS_READ          8'h4B
`define OP_DEVICE_ID_READ   8'h9F
`define OP_UNIQUE_ID_READ   8'h4C
`define OP_SERIAL_WRITE     8'hC2
`define OP_SERIAL_READ      8'hC3
`define OP_DEEP_SLEEP       8'hBA
`define OP_HIBERNATE        8'hB9

// status field positions
`define ST_PIN_EN_BIT       7
`define ST_FIXED_ONE_BIT    6
`define ST_BP_HIGH_BIT      3
`define ST_BP_LOW_BIT       2
`define ST_WEL_BIT          1
`define ST_READY_BIT        0

// protected region bounds (21-bit array address)
`define QUARTER_BASE        21'h180000
`define HALF_BASE           21'h100000

// wake time after a low-power command, given in ns and turned into cycles of clk
`define WAKE_TIME_NS        1000
`define CLK_PERIOD_NS       50
`define WAKE_CYCLES         (`WAKE_TIME_NS / `CLK_PERIOD_NS)

`endif

// file: spi_fram_pkg.sv
package spi_fram_pkg;

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_LATCH_SET,
    CMD_LATCH_CLEAR,
    CMD_STATUS_READ,
    CMD_STATUS_WRITE,
    CMD_ARRAY_WRITE,
    CMD_ARRAY_READ,
    CMD_FAST_READ,
    CMD_SS_WRITE,
    CMD_SS_READ,
    CMD_DEVICE_ID,
    CMD_UNIQUE_ID,
    CMD_SERIAL_WRITE,
    CMD_SERIAL_READ,
    CMD_DEEP_SLEEP,
    CMD_HIBERNATE
  } cmd_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_BODY,
    PH_IGNORE
  } phase_type;

endpackage

// file: sync_two_ff.sv
`timescale 1ns/10ps

module sync_two_ff (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // level in other domain
  input  wire logic async_in,
  input  wire logic reset_value,
  // synchronised level
  output logic      sync_out
);

  logic meta_reg;

  // reset loads zero; reset_value, a constant tie at the instance, inverts the input when tied high
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in ^ reset_value;
      sync_out <= meta_reg;
    end
  end

endmodule

// file: spi_fram_cmd.sv
`timescale 1ns/10ps
`include "spi_fram_cfg.svh"

// Overview of operation
// - opcode 06h sets the write-enable latch
// - opcode 04h clears the write-enable latch
// - opcode 05h shifts out exactly one status byte
// - opcode 01h plus data byte updates pin enable and block-protect bits
// - 02h is array write, 03h array read, 0Bh fast array read
// - fifteen opcodes recognised including special, ID, serial and low-power codes
// - write-enable flag, status bit 1, reads zero after power-up
// - status write data never writes the write-enable flag; the flag clears when it ends
// - latch clears on chip-select rise ending clear or any write command
// - status bits: 7 pin enable, 3 and 2 block protect, 1 latch
// - bits 0, 4, 5 read zero, bit 6 reads one, unwritable
// - bit 0 reads zero except while waking from low-power modes
// - block-protect bits are nonvolatile and not reset at power-up
// - block protect selects none, upper quarter, upper half or all
// - pin enable high with protect pin low rejects status writes
// - protect pin never blocks array writes
// - array writes blocked only by clear latch or protected address
// - array write bytes accepted back to back with no busy time
// - first byte after chip-select fall is the single opcode
// - undefined opcode ignored with output tristated until next select
// - mode 0 or 3 from clock level at select; sample rise, drive fall

module spi_fram_cmd (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // spi pins
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  input  wire logic        wp_n,
  // array side
  output logic             array_write_stb,
  output logic [20:0]      array_addr,
  output logic [7:0]       array_wdata,
  output logic [3:0]       active_cmd,
  output logic [7:0]       protection_status
);

  logic sck_s;
  logic cs_s;
  logic si_s;
  logic wp_s;
  logic sck_d_reg;
  logic cs_d_reg;

  // pins pass two flops; cs and wp idle high so invert through the sync
  sync_two_ff u_sck (.clk(clk), .reset(reset), .async_in(sck), .reset_value(1'b0),
                     .sync_out(sck_s));
  sync_two_ff u_cs (.clk(clk), .reset(reset), .async_in(cs_n), .reset_value(1'b1),
                    .sync_out(cs_s));
  sync_two_ff u_si (.clk(clk), .reset(reset), .async_in(si), .reset_value(1'b0),
                    .sync_out(si_s));
  sync_two_ff u_wp (.clk(clk), .reset(reset), .async_in(wp_n), .reset_value(1'b1),
                    .sync_out(wp_s));

  // cs_s and wp_s are inverted: cs_s high means selected, wp_s high means pin low
  logic selected;
  logic wp_low;
  assign selected = cs_s;
  assign wp_low   = wp_s;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b0;
    end else begin
      sck_d_reg <= sck_s;
      cs_d_reg  <= selected;
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  assign sel_fall = selected & ~cs_d_reg;
  assign sel_rise = ~selected & cs_d_reg;
  assign sck_rise = selected & cs_d_reg & sck_s & ~sck_d_reg;
  assign sck_fall = selected & cs_d_reg & ~sck_s & sck_d_reg;

  // mode 3 starts with clock high: its first fall drives nothing, edges are the same
  logic mode3_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      mode3_reg <= 1'b0;
    end else if (sel_fall) begin
      mode3_reg <= sck_s;
    end
  end

  spi_fram_pkg::phase_type phase_reg;
  spi_fram_pkg::cmd_type   cmd_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [5:0]  byte_cnt_reg;
  logic        byte_done;
  logic [7:0]  byte_val;

  assign byte_val  = {shift_reg[6:0], si_s};
  assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);

  function automatic spi_fram_pkg::cmd_type decode(input logic [7:0] op);
    case (op)
      `OP_LATCH_SET:       decode = spi_fram_pkg::CMD_LATCH_SET;
      `OP_LATCH_CLEAR:     decode = spi_fram_pkg::CMD_LATCH_CLEAR;
      `OP_STATUS_READ:     decode = spi_fram_pkg::CMD_STATUS_READ;
      `OP_STATUS_WRITE:    decode = spi_fram_pkg::CMD_STATUS_WRITE;
      `OP_ARRAY_WRITE:     decode = spi_fram_pkg::CMD_ARRAY_WRITE;
      `OP_ARRAY_READ:      decode = spi_fram_pkg::CMD_ARRAY_READ;
      `OP_FAST_ARRAY_READ: decode = spi_fram_pkg::CMD_FAST_READ;
      `OP_SS_WRITE:        decode = spi_fram_pkg::CMD_SS_WRITE;
      `OP_SS_READ:         decode = spi_fram_pkg::CMD_SS_READ;
      `OP_DEVICE_ID_READ:  decode = spi_fram_pkg::CMD_DEVICE_ID;
      `OP_UNIQUE_ID_READ:  decode = spi_fram_pkg::CMD_UNIQUE_ID;
      `OP_SERIAL_WRITE:    decode = spi_fram_pkg::CMD_SERIAL_WRITE;
      `OP_SERIAL_READ:     decode = spi_fram_pkg::CMD_SERIAL_READ;
      `OP_DEEP_SLEEP:      decode = spi_fram_pkg::CMD_DEEP_SLEEP;
      `OP_HIBERNATE:       decode = spi_fram_pkg::CMD_HIBERNATE;
      default:             decode = spi_fram_pkg::CMD_NONE;
    endcase
  endfunction

  // bit and byte counting
  always_ff @(posedge clk) begin
    if (reset || sel_fall) begin
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 6'h00;
    end else if (sck_rise) begin
      shift_reg   <= byte_val;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done && byte_cnt_reg != 6'h3F) begin
        byte_cnt_reg <= byte_cnt_reg + 6'h01;
      end
    end
  end

  // phase: one opcode per select, unknown opcodes put the decoder to sleep
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= spi_fram_pkg::PH_IDLE;
      cmd_reg   <= spi_fram_pkg::CMD_NONE;
    end else if (sel_fall) begin
      phase_reg <= spi_fram_pkg::PH_OPCODE;
      cmd_reg   <= spi_fram_pkg::CMD_NONE;
    end else if (sel_rise) begin
      phase_reg <= spi_fram_pkg::PH_IDLE;
      cmd_reg   <= spi_fram_pkg::CMD_NONE;
    end else begin
      case (phase_reg)
        spi_fram_pkg::PH_OPCODE: begin
          if (byte_done) begin
            cmd_reg <= decode(byte_val);
            if (decode(byte_val) == spi_fram_pkg::CMD_NONE) begin
              phase_reg <= spi_fram_pkg::PH_IGNORE;
            end else begin
              phase_reg <= spi_fram_pkg::PH_BODY;
            end
          end
        end
        spi_fram_pkg::PH_IDLE,
        spi_fram_pkg::PH_BODY,
        spi_fram_pkg::PH_IGNORE: begin
          phase_reg <= phase_reg;
        end
        default: phase_reg <= spi_fram_pkg::PH_IDLE;
      endcase
    end
  end

  // status bits; block protect has no reset to stand in for nonvolatile cells
  logic       latch_reg;
  logic       pin_en_reg;
  logic [1:0] bp_reg;
  logic       in_body;
  logic       status_wr_ok;
  logic       ends_write;
  assign in_body = (phase_reg == spi_fram_pkg::PH_BODY);
  assign status_wr_ok = latch_reg & ~(pin_en_reg & wp_low);
  assign ends_write = (cmd_reg == spi_fram_pkg::CMD_LATCH_CLEAR)
                    | (cmd_reg == spi_fram_pkg::CMD_STATUS_WRITE)
                    | (cmd_reg == spi_fram_pkg::CMD_ARRAY_WRITE)
                    | (cmd_reg == spi_fram_pkg::CMD_SS_WRITE)
                    | (cmd_reg == spi_fram_pkg::CMD_SERIAL_WRITE);

  always_ff @(posedge clk) begin
    if (reset) begin
      latch_reg <= 1'b0;
    end else if (sel_rise && in_body && cmd_reg == spi_fram_pkg::CMD_LATCH_SET) begin
      latch_reg <= 1'b1;
    end else if (sel_rise && in_body && ends_write) begin
      latch_reg <= 1'b0;
    end
  end

  // data byte applied only on its eighth bit; the latch is never written here
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_en_reg <= 1'b0;
    end else if (in_body && cmd_reg == spi_fram_pkg::CMD_STATUS_WRITE && byte_done
                 && byte_cnt_reg == 6'h01 && status_wr_ok) begin
      pin_en_reg <= byte_val[`ST_PIN_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (in_body && cmd_reg == spi_fram_pkg::CMD_STATUS_WRITE && byte_done
        && byte_cnt_reg == 6'h01 && status_wr_ok) begin
      bp_reg <= byte_val[`ST_BP_HIGH_BIT:`ST_BP_LOW_BIT];
    end
  end

  // wake timer after a low-power command ends
  logic [7:0] wake_cnt_reg;
  logic       low_power;
  assign low_power = (cmd_reg == spi_fram_pkg::CMD_DEEP_SLEEP)
                   | (cmd_reg == spi_fram_pkg::CMD_HIBERNATE);
  always_ff @(posedge clk) begin
    if (reset) begin
      wake_cnt_reg <= 8'h00;
    end else if (sel_rise && in_body && low_power) begin
      wake_cnt_reg <= 8'(`WAKE_CYCLES);
    end else if (wake_cnt_reg != 8'h00) begin
      wake_cnt_reg <= wake_cnt_reg - 8'h01;
    end
  end

  logic [7:0] status_val;
  always_comb begin
    status_val = 8'h00;
    status_val[`ST_FIXED_ONE_BIT] = 1'b1;
    status_val[`ST_PIN_EN_BIT] = pin_en_reg;
    status_val[`ST_BP_HIGH_BIT] = bp_reg[1];
    status_val[`ST_BP_LOW_BIT] = bp_reg[0];
    status_val[`ST_WEL_BIT] = latch_reg;
    status_val[`ST_READY_BIT] = (wake_cnt_reg != 8'h00);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      protection_status <= 8'h40;
    end else begin
      protection_status <= status_val;
    end
  end

  // array address and data framing
  logic [20:0] addr_reg;
  logic        blocked;
  always_comb begin
    case (bp_reg)
      2'b00:   blocked = 1'b0;
      2'b01:   blocked = (addr_reg >= `QUARTER_BASE);
      2'b10:   blocked = (addr_reg >= `HALF_BASE);
      default: blocked = 1'b1;
    endcase
  end

  logic arr_wr;
  assign arr_wr = in_body && cmd_reg == spi_fram_pkg::CMD_ARRAY_WRITE;

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg <= 21'h000000;
    end else if (arr_wr && byte_done && byte_cnt_reg >= 6'h01 && byte_cnt_reg <= 6'h03) begin
      addr_reg <= {addr_reg[12:0], byte_val};
    end else if (arr_wr && byte_done && byte_cnt_reg >= 6'h04
                 && latch_reg && !blocked) begin
      addr_reg <= addr_reg + 21'h000001;
    end
  end

  // latch and block protect gate array writes; the pin plays no part
  always_ff @(posedge clk) begin
    if (reset) begin
      array_write_stb <= 1'b0;
      array_wdata     <= 8'h00;
      array_addr      <= 21'h000000;
    end else begin
      array_write_stb <= arr_wr && byte_done && byte_cnt_reg >= 6'h04
                         && latch_reg && !blocked;
      if (arr_wr && byte_done && byte_cnt_reg >= 6'h04) begin
        array_wdata <= byte_val;
        array_addr  <= addr_reg;
      end
    end
  end

  assign active_cmd = cmd_reg;

  // status byte out: msb first, advanced on falling edges
  logic [7:0] out_reg;
  logic [3:0] out_left_reg;
  always_ff @(posedge clk) begin
    if (reset || !selected) begin
      out_reg      <= 8'h00;
      out_left_reg <= 4'h0;
    end else if (phase_reg == spi_fram_pkg::PH_OPCODE && byte_done
                 && decode(byte_val) == spi_fram_pkg::CMD_STATUS_READ) begin
      out_reg      <= status_val;
      out_left_reg <= 4'h8;
    end else if (sck_fall && out_left_reg != 4'h0 && bit_cnt_reg == 3'h0
                 && byte_cnt_reg == 6'h01 && out_left_reg == 4'h8) begin
      out_left_reg <= 4'h8;
    end else if (sck_fall && out_left_reg != 4'h0 && bit_cnt_reg != 3'h0) begin
      out_reg      <= {out_reg[6:0], 1'b0};
      out_left_reg <= out_left_reg - 4'h1;
    end else if (byte_done && byte_cnt_reg == 6'h01) begin
      out_left_reg <= 4'h0;
    end
  end

  // straight from the shift flop: one more stage would miss the master's next rise
  assign so = out_reg[7];
  always_ff @(posedge clk) begin
    if (reset) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= selected && in_body && cmd_reg == spi_fram_pkg::CMD_STATUS_READ
               && byte_cnt_reg == 6'h01;
    end
  end

  a_latch_set_on_rise: assert property (@(posedge clk) disable iff (reset)
    (sel_rise && in_body && cmd_reg == spi_fram_pkg::CMD_LATCH_SET) |=> latch_reg)
    else $error("latch not set after set command");

  a_latch_cleared: assert property (@(posedge clk) disable iff (reset)
    (sel_rise && in_body && ends_write) |=> !latch_reg)
    else $error("latch not cleared after write command");

  a_fixed_bits: assert property (@(posedge clk) disable iff (reset)
    protection_status[6] && protection_status[5:4] == 2'b00)
    else $error("fixed status bits wrong");

  a_no_wr_unlatched: assert property (@(posedge clk) disable iff (reset)
    array_write_stb |-> $past(latch_reg))
    else $error("array write without latch");

  a_pin_guard: assert property (@(posedge clk) disable iff (reset)
    (pin_en_reg && wp_low) |=> $stable(bp_reg))
    else $error("status changed while pin protected");

  a_ignore_quiet: assert property (@(posedge clk) disable iff (reset)
    (phase_reg == spi_fram_pkg::PH_IGNORE) |-> !so_oe)
    else $error("output driven after bad opcode");

  a_mode_capture: assert property (@(posedge clk) disable iff (reset)
    sel_fall |=> (mode3_reg == $past(sck_s)))
    else $error("mode not captured");

  a_wel_unwritten: assert property (@(posedge clk) disable iff (reset)
    (!sel_rise) |=> $stable(latch_reg))
    else $error("latch changed outside select rise");

endmodule

// file: spi_master_model.sv
`timescale 1ns/10ps

module spi_master_model (
  // clock
  input  wire logic clk,
  // spi pins
  input  wire logic so,
  input  wire logic so_oe,
  output logic      sck,
  output logic      cs_n,
  output logic      si
);
  logic mode_reg;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    mode_reg = 1'b0;
  end
  // idle clock level chosen before the select edge picks the mode
  task automatic select(input logic mode3);
    mode_reg = mode3;
    sck <= mode3;
    repeat (4) @(posedge clk);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // 400 ns bit time, msb first; an undriven output reads as z
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      rx[i] = so_oe ? so : 1'bz;
      repeat (4) @(posedge clk);
    end
  endtask
  // released data line shows the inverse of its last bit
  task automatic deselect();
    sck <= mode_reg;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: spi_fram_cmd_tb.sv
`timescale 1ns/10ps

module spi_fram_cmd_tb;
  logic        clk, reset, wp_n;
  logic        sck, cs_n, si, so, so_oe;
  logic        array_write_stb;
  logic [20:0] array_addr;
  logic [7:0]  array_wdata;
  logic [3:0]  active_cmd;
  logic [7:0]  protection_status;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic        seen_busy = 1'b0, seen_oe = 1'b0;
  logic [20:0] wq_addr[$];
  logic [7:0]  wq_data[$];
  logic [7:0]  s;
  logic [7:0]  ops[15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h42,
                           8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9};
  logic [20:0] tgt[3] = '{21'h0FFFFF, 21'h100000, 21'h180000};
  logic [14:0] wclr = 15'h089A;
  logic [14:0] lowp = 15'h6000;
  logic [11:0] bpmap = 12'hFA0;
  spi_fram_cmd dut (
    .clk(clk), .reset(reset), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .wp_n(wp_n), .array_write_stb(array_write_stb), .array_addr(array_addr),
    .array_wdata(array_wdata), .active_cmd(active_cmd),
    .protection_status(protection_status));
  spi_master_model master (
    .clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si));
  always #25 clk = ~clk;
  // monitor plus hang guard; a run this long means a wait never ended
  always @(posedge clk) begin
    cycles++;
    if (array_write_stb === 1'b1) begin
      wq_addr.push_back(array_addr);
      wq_data.push_back(array_wdata);
    end
    if (protection_status[0] === 1'b1) seen_busy = 1'b1;
    if (so_oe === 1'b1) seen_oe = 1'b1;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic m, input logic [7:0] op, input logic [7:0] d,
                       input int nb, output logic [7:0] rx);
    master.select(m);
    master.xfer(op, 8, rx);
    if (nb > 0) master.xfer(d, nb, rx);
    master.deselect();
  endtask
  task automatic latch_set_cmd();
    logic [7:0] rx;
    frame(1'b0, 8'h06, 8'h00, 0, rx);
  endtask
  task automatic set_status(input logic [7:0] v);
    logic [7:0] rx;
    latch_set_cmd();
    frame(1'b0, 8'h01, v, 8, rx);
  endtask
  task automatic status(input logic m);
    frame(m, 8'h05, 8'h00, 8, s);
  endtask
  task automatic awrite(input logic [20:0] a, input logic [7:0] d0, input int n);
    logic [7:0] rx;
    master.select(1'b0);
    master.xfer(8'h02, 8, rx);
    master.xfer({3'h0, a[20:16]}, 8, rx);
    master.xfer(a[15:8], 8, rx);
    master.xfer(a[7:0], 8, rx);
    for (int k = 0; k < n; k++) master.xfer(d0 + 8'(k), 8, rx);
    master.deselect();
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    logic [7:0] rx;
    clk = 1'b0;
    reset = 1'b1;
    wp_n = 1'b1;
    do_reset();
    check(protection_status & 8'hF3, 8'h40);
    status(1'b0);
    check(s & 8'hF3, 8'h40);
    frame(1'b0, 8'h01, 8'h80, 8, rx);
    status(1'b0);
    check(s & 8'hF3, 8'h40);
    latch_set_cmd();
    status(1'b1);
    check(s & 8'hF3, 8'h42);
    frame(1'b0, 8'h01, 8'hFF, 8, rx);
    status(1'b0);
    check(s, 8'hCC);
    check(protection_status, 8'hCC);
    latch_set_cmd();
    frame(1'b0, 8'h04, 8'h00, 0, rx);
    status(1'b0);
    check(s, 8'hCC);
    wp_n <= 1'b0;
    set_status(8'h00);
    status(1'b0);
    check(s, 8'hCC);
    wp_n <= 1'b1;
    set_status(8'h00);
    wp_n <= 1'b0;
    set_status(8'h04);
    status(1'b0);
    check(s, 8'h44);
    latch_set_cmd();
    frame(1'b0, 8'h01, 8'hFF, 7, rx);
    check(protection_status & 8'hFD, 8'h44);
    do_reset();
    check(protection_status & 8'h0E, 8'h04);
    // burst runs from open space into the protected quarter with the pin low
    latch_set_cmd();
    wq_addr.delete();
    wq_data.delete();
    awrite(21'h17FFFE, 8'hA0, 3);
    check(21'(wq_addr.size()), 21'h2);
    check(wq_addr[1], 21'h17FFFF);
    check(21'(wq_data[1]), 21'hA1);
    awrite(21'h000010, 8'h55, 1);
    check(21'(wq_addr.size()), 21'h2);
    for (int b = 0; b < 4; b++) begin
      set_status({4'h0, 2'(b), 2'b00});
      for (int j = 0; j < 3; j++) begin
        latch_set_cmd();
        wq_addr.delete();
        awrite(tgt[j], 8'h11, 1);
        check(21'(wq_addr.size()), 21'(bpmap[11 - 3 * b - j]));
      end
    end
    seen_busy = 1'b0;
    for (int i = 0; i < 15; i++) begin
      latch_set_cmd();
      master.select(1'b0);
      master.xfer(ops[i], 8, rx);
      repeat (2) @(posedge clk);
      check(active_cmd, 21'(i + 1));
      master.deselect();
      repeat (40) @(posedge clk);
      status(1'b0);
      check(s & {6'h00, ~lowp[i], 1'b1}, {6'h00, ~lowp[i] & ~wclr[i], 1'b0});
    end
    check(seen_busy, 1'b1);
    seen_oe = 1'b0;
    master.select(1'b0);
    master.xfer(8'hFF, 8, rx);
    master.xfer(8'h05, 8, rx);
    check(active_cmd, 21'h0);
    master.deselect();
    check(seen_oe, 1'b0);
    end_of_test();
  end
endmodule
